// File: core/nfc_pkg.sv
// Function
// - command byte: cle high, ale low, ce low
// - address byte: ale high, cle low, ce low
// - data in needs both latches low, wp high
// - five address cycles, zero padding bits
// - read 00/30, colchg 05/e0, prog 80/10, erase 60/d0
// - 85, 80-11 81-10, 00-35, 85-10
// - 90,70,71,7a,ff; busy accepts 70,71,ff
// - host holds read strobe high during read busy
package nfc_pkg;
   localparam logic [7:0] CMD_READ1  = 8'h00;
   localparam logic [7:0] CMD_READ2  = 8'h30;
   localparam logic [7:0] CMD_COL1   = 8'h05;
   localparam logic [7:0] CMD_COL2   = 8'he0;
   localparam logic [7:0] CMD_PROG1  = 8'h80;
   localparam logic [7:0] CMD_PROG2  = 8'h10;
   localparam logic [7:0] CMD_ERASE1 = 8'h60;
   localparam logic [7:0] CMD_ERASE2 = 8'hd0;
   localparam logic [7:0] CMD_COLIN  = 8'h85;
   localparam logic [7:0] CMD_MPROG  = 8'h11;
   localparam logic [7:0] CMD_MPROG2 = 8'h81;
   localparam logic [7:0] CMD_CPBK   = 8'h35;
   localparam logic [7:0] CMD_ID     = 8'h90;
   localparam logic [7:0] CMD_STAT   = 8'h70;
   localparam logic [7:0] CMD_MSTAT  = 8'h71;
   localparam logic [7:0] CMD_ECCST  = 8'h7a;
   localparam logic [7:0] CMD_RESET  = 8'hff;
   localparam int PAGE_BYTES   = 4224;
   localparam int BLOCK_PAGES  = 64;
   localparam int BLOCKS       = 4096;
   localparam int PAGE_BITS    = 6;
   // register offsets of the controller's own port
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_COL    = 4'h1;
   localparam logic [3:0] REG_ROW    = 4'h2;
   localparam logic [3:0] REG_DATA   = 4'h3;
   localparam logic [3:0] REG_STAT   = 4'h4;
   localparam logic [3:0] REG_CMD    = 4'h5;
   // ctrl op codes written to REG_CTRL[2:0]
   localparam logic [2:0] OP_CMD  = 3'h1;
   localparam logic [2:0] OP_ADDR = 3'h2;
   localparam logic [2:0] OP_WR   = 3'h3;
   localparam logic [2:0] OP_RD   = 3'h4;
   localparam logic [2:0] OP_PGRD = 3'h5;
   localparam logic [2:0] OP_COLC = 3'h6;
   // timing in ns at 100 mhz, least times round up
   localparam int CLK_NS   = 10;
   localparam int TWP_NS   = 12;
   localparam int TWH_NS   = 10;
   localparam int TRP_NS   = 12;
   localparam int TREH_NS  = 10;
   localparam int TWHR_NS  = 60;
   localparam int TWB_NS   = 100;
   localparam int TWP_CYC  = (TWP_NS + CLK_NS - 1) / CLK_NS;
   localparam int TWH_CYC  = (TWH_NS + CLK_NS - 1) / CLK_NS;
   localparam int TRP_CYC  = (TRP_NS + CLK_NS - 1) / CLK_NS + 1;
   localparam int TREH_CYC = (TREH_NS + CLK_NS - 1) / CLK_NS;
   localparam int TWHR_CYC = (TWHR_NS + CLK_NS - 1) / CLK_NS;
   localparam int TWB_CYC  = (TWB_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] CNT_W = 8'h00;
endpackage

// File: core/nfc_strobe_if.sv
`timescale 1ns/1ns
// one strobe pulse request between sequencer and pulse timer
interface nfc_strobe_if;
   logic       go;
   logic       is_read;
   logic [7:0] low_cyc;
   logic [7:0] high_cyc;
   logic       busy;
   logic       low;
   logic       sample;
   modport master (output go, output is_read, output low_cyc,
                   output high_cyc, input busy, input low,
                   input sample);
   modport timer  (input go, input is_read, input low_cyc,
                   input high_cyc, output busy, output low,
                   output sample);
endinterface

// File: core/nfc_pulse.sv
`timescale 1ns/1ns
// shapes one low pulse followed by a high recovery time
module nfc_pulse (
   input  wire logic clk,
   input  wire logic rst,
   nfc_strobe_if.timer s
);
   logic [7:0] cnt_q, cnt_d;
   logic       low_q, low_d;
   logic       act_q, act_d;
   logic       smp_d;

   // count low phase then high phase; sample at end of low phase
   always_comb begin
      cnt_d = cnt_q;
      low_d = low_q;
      act_d = act_q;
      smp_d = 1'b0;
      if (!act_q && s.go) begin
         act_d = 1'b1;
         low_d = 1'b1;
         cnt_d = s.low_cyc;
      end else if (act_q) begin
         if (cnt_q > 8'h01) begin
            cnt_d = cnt_q - 8'h01;
         end else if (low_q) begin
            low_d = 1'b0;
            smp_d = s.is_read; // last low cycle, device still drives
            cnt_d = s.high_cyc;
         end else begin
            act_d = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 8'h00;
         low_q <= 1'b0;
         act_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         low_q <= low_d;
         act_q <= act_d;
      end
   end

   assign s.busy   = act_q;
   assign s.low    = low_d;
   // a registered sample would land after release, on a floating bus
   assign s.sample = smp_d;
endmodule

// File: core/nfc_host.sv
`timescale 1ns/1ns
// host side nand sequencer behind a small register port
module nfc_host (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata,
   output logic            cle,
   output logic            ale,
   output logic            ce_n,
   output logic            we_n,
   output logic            read_strobe_low,
   output logic            wp_n,
   output logic [7:0]      byte_out,
   output logic            byte_oe_n,
   input  wire logic [7:0] shared_byte_lines,
   input  wire logic       ready_busy_flag
);
   typedef enum {NFC_IDLE, NFC_CMD, NFC_ADDR, NFC_WR, NFC_RD,
                 NFC_WAITB, NFC_WAITR, NFC_GAP} nfc_state_e;

   nfc_strobe_if s ();
   nfc_pulse u_pulse (.clk(clk), .rst(rst), .s(s));

   nfc_state_e st_q, st_d;
   logic [7:0]  rd_q, rd_d;
   logic        cle_q, cle_d, ale_q, ale_d, ce_q, ce_d;
   logic        oe_n_q, oe_n_d, wp_q, wp_d;
   logic [7:0]  bo_q, bo_d, dat_q, dat_d, cmd_q, cmd_d;
   logic [12:0] col_q, col_d;
   logic [17:0] row_q, row_d;
   logic [2:0]  op_q, op_d, acnt_q, acnt_d;
   logic        err_q, err_d, go_q, go_d, rdv_q, rdv_d;
   logic [7:0]  wt_q, wt_d;
   logic        started_q, started_d;
   logic        busy_cmd;
   logic [7:0]  abyte;

   // only these may go out by OP_CMD while the device is busy
   assign busy_cmd = (cmd_q == nfc_pkg::CMD_STAT) |
                     (cmd_q == nfc_pkg::CMD_MSTAT) |
                     (cmd_q == nfc_pkg::CMD_RESET);

   // five address bytes, padding bits forced low
   always_comb begin
      case (acnt_q)
         3'h0: abyte = col_q[7:0];
         3'h1: abyte = {3'h0, col_q[12:8]};
         3'h2: abyte = row_q[7:0];
         3'h3: abyte = row_q[15:8];
         default: abyte = {6'h00, row_q[17:16]};
      endcase
   end

   // sequencer: one strobe per byte, waits on busy flag
   always_comb begin
      st_d = st_q; cle_d = cle_q; ale_d = ale_q; ce_d = ce_q;
      oe_n_d = oe_n_q; bo_d = bo_q; dat_d = dat_q; cmd_d = cmd_q;
      col_d = col_q; row_d = row_q; op_d = op_q; acnt_d = acnt_q;
      err_d = err_q; go_d = 1'b0; wt_d = wt_q; wp_d = wp_q;
      started_d = started_q;
      rd_d = 8'h00;
      rdv_d = rdv_q;
      if (rd) begin
         case (addr)
            nfc_pkg::REG_STAT: rd_d = {3'h0, rdv_q, wp_q, err_q,
                                      ready_busy_flag,
                                      st_q != NFC_IDLE};
            nfc_pkg::REG_DATA: begin
               rd_d = dat_q;
               rdv_d = 1'b0;
            end
            nfc_pkg::REG_COL:  rd_d = col_q[7:0];
            nfc_pkg::REG_ROW:  rd_d = row_q[7:0];
            nfc_pkg::REG_CMD:  rd_d = cmd_q;
            default:           rd_d = 8'h00;
         endcase
      end
      if (wr && st_q == NFC_IDLE) begin
         case (addr)
            nfc_pkg::REG_COL:  col_d = {col_q[4:0], wdata};
            nfc_pkg::REG_ROW:  row_d = {row_q[9:0], wdata};
            nfc_pkg::REG_DATA: dat_d = wdata;
            nfc_pkg::REG_CMD:  cmd_d = wdata;
            nfc_pkg::REG_CTRL: begin
               op_d = wdata[2:0];
               wp_d = wdata[7];
               err_d = 1'b0;
               if (wdata[2:0] != 3'h0) begin
                  if (!ready_busy_flag && !busy_cmd
                      && wdata[2:0] == nfc_pkg::OP_CMD) begin
                     err_d = 1'b1;
                  end else begin
                     ce_d = 1'b0;
                     st_d = NFC_GAP;
                     acnt_d = 3'h0;
                  end
               end else begin
                  ce_d = 1'b1;
               end
            end
            default: ;
         endcase
      end
      case (st_q)
         NFC_IDLE: ;
         NFC_GAP: begin
            oe_n_d = 1'b1;
            cle_d = 1'b0;
            ale_d = 1'b0;
            case (op_q)
               nfc_pkg::OP_CMD: st_d = NFC_CMD;
               nfc_pkg::OP_ADDR, nfc_pkg::OP_PGRD: st_d = NFC_ADDR;
               nfc_pkg::OP_COLC: begin
                  cmd_d = nfc_pkg::CMD_COL1;
                  st_d = NFC_CMD;
               end
               nfc_pkg::OP_WR: begin
                  if (wp_q) st_d = NFC_WR;
                  else begin
                     err_d = 1'b1;
                     st_d = NFC_IDLE;
                  end
               end
               nfc_pkg::OP_RD: st_d = NFC_RD;
               default: st_d = NFC_IDLE;
            endcase
         end
         NFC_CMD: begin
            cle_d = 1'b1;
            ale_d = 1'b0;
            oe_n_d = 1'b0;
            bo_d = cmd_q;
            if (!started_q && !s.busy) begin
               go_d = 1'b1;
               started_d = 1'b1;
            end else if (started_q && !s.busy && !go_q) begin
               started_d = 1'b0;
               cle_d = 1'b0;
               if (op_q == nfc_pkg::OP_COLC &&
                   cmd_q == nfc_pkg::CMD_COL1) begin
                  st_d = NFC_ADDR;
               end else if (op_q == nfc_pkg::OP_PGRD ||
                            cmd_q == nfc_pkg::CMD_CPBK) begin
                  wt_d = 8'(nfc_pkg::TWB_CYC);
                  st_d = NFC_WAITB;
               end else begin
                  wt_d = 8'(nfc_pkg::TWHR_CYC);
                  st_d = NFC_WAITR;
               end
            end
         end
         NFC_ADDR: begin
            ale_d = 1'b1;
            cle_d = 1'b0;
            oe_n_d = 1'b0;
            bo_d = abyte;
            if (!started_q && !s.busy) begin
               go_d = 1'b1;
               started_d = 1'b1;
            end else if (started_q && !s.busy && !go_q) begin
               started_d = 1'b0;
               acnt_d = acnt_q + 3'h1;
               // column change sends two column bytes only
               if ((op_q == nfc_pkg::OP_COLC && acnt_q == 3'h1) ||
                   acnt_q == 3'h4) begin
                  ale_d = 1'b0;
                  st_d = NFC_CMD;
                  if (op_q == nfc_pkg::OP_COLC)
                     cmd_d = nfc_pkg::CMD_COL2;
                  else if (op_q == nfc_pkg::OP_PGRD)
                     cmd_d = nfc_pkg::CMD_READ2;
                  else begin
                     st_d = NFC_IDLE;
                  end
               end
            end
         end
         NFC_WR: begin
            oe_n_d = 1'b0;
            bo_d = dat_q;
            if (!started_q && !s.busy) begin
               go_d = 1'b1;
               started_d = 1'b1;
            end else if (started_q && !s.busy && !go_q) begin
               started_d = 1'b0;
               st_d = NFC_IDLE;
            end
         end
         NFC_RD: begin
            oe_n_d = 1'b1;
            if (!ready_busy_flag) begin
               st_d = NFC_RD;
            end else if (!started_q && !s.busy) begin
               go_d = 1'b1;
               started_d = 1'b1;
            end else if (started_q && !s.busy && !go_q) begin
               started_d = 1'b0;
               st_d = NFC_IDLE;
            end
            if (s.sample) begin
               dat_d = shared_byte_lines;
               rdv_d = 1'b1;
            end
         end
         NFC_WAITB: begin
            oe_n_d = 1'b1;
            if (wt_q != 8'h00) wt_d = wt_q - 8'h01;
            else if (ready_busy_flag) st_d = NFC_IDLE;
         end
         NFC_WAITR: begin
            oe_n_d = 1'b1;
            if (wt_q != 8'h00) wt_d = wt_q - 8'h01;
            else st_d = NFC_IDLE;
         end
         default: st_d = NFC_IDLE;
      endcase
   end

   // pulse timer request; write or read by state
   assign s.go       = go_q;
   assign s.is_read  = (st_q == NFC_RD);
   assign s.low_cyc  = (st_q == NFC_RD) ? 8'(nfc_pkg::TRP_CYC)
                                        : 8'(nfc_pkg::TWP_CYC);
   assign s.high_cyc = (st_q == NFC_RD) ? 8'(nfc_pkg::TREH_CYC)
                                        : 8'(nfc_pkg::TWH_CYC);

   logic we_d, re_d, we_q, re_q;
   // strobe edges only while ce low keeps device from latching
   always_comb begin
      we_d = !(s.low && !s.is_read && !ce_q);
      re_d = !(s.low && s.is_read && !ce_q);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= NFC_IDLE;
         cle_q <= 1'b0; ale_q <= 1'b0; ce_q <= 1'b1;
         oe_n_q <= 1'b1; bo_q <= 8'h00; dat_q <= 8'h00;
         cmd_q <= nfc_pkg::CMD_READ1;
         col_q <= 13'h0000; row_q <= 18'h00000;
         op_q <= 3'h0; acnt_q <= 3'h0; err_q <= 1'b0;
         go_q <= 1'b0; wt_q <= 8'h00; wp_q <= 1'b0;
         started_q <= 1'b0; rd_q <= 8'h00; rdv_q <= 1'b0;
         we_q <= 1'b1; re_q <= 1'b1;
      end else begin
         st_q <= st_d;
         cle_q <= cle_d; ale_q <= ale_d; ce_q <= ce_d;
         oe_n_q <= oe_n_d; bo_q <= bo_d; dat_q <= dat_d;
         cmd_q <= cmd_d; col_q <= col_d; row_q <= row_d;
         op_q <= op_d; acnt_q <= acnt_d; err_q <= err_d;
         go_q <= go_d; wt_q <= wt_d; wp_q <= wp_d;
         started_q <= started_d; rd_q <= rd_d; rdv_q <= rdv_d;
         we_q <= we_d; re_q <= re_d;
      end
   end

   assign rdata           = rd_q;
   assign cle             = cle_q;
   assign ale             = ale_q;
   assign ce_n            = ce_q;
   assign we_n            = we_q;
   assign read_strobe_low = re_q;
   assign wp_n            = wp_q;
   assign byte_out        = bo_q;
   assign byte_oe_n       = oe_n_q;
endmodule

// File: verif/nfc_flash_model.sv
`timescale 1ns/1ns
// behavioural nand device, timed by strobe edges and a 600 ns busy delay
module nfc_flash_model (
   input  wire logic       cle,
   input  wire logic       ale,
   input  wire logic       ce_n,
   input  wire logic       we_n,
   input  wire logic       read_strobe_low,
   input  wire logic       wp_n,
   input  wire logic [7:0] lines,
   output logic [7:0]      dev_byte,
   output logic            dev_oe_n,
   output logic            rb_oe_n
);
   logic [7:0]  cmd = 8'h00;
   logic [7:0]  ab [5];
   logic [7:0]  din = 8'h00;
   logic [12:0] col = 13'h0000;
   logic        rdy = 1'b1;
   int          na = 0;
   int          nd = 0;
   initial dev_byte = 8'h00;
   // capture on rising write strobe; deselect or both latches ignores it
   always @(posedge we_n) begin
      if (!ce_n && !(cle && ale)) begin
         if (cle && (rdy || lines inside {8'h70, 8'h71, 8'hff})) begin
            cmd = lines;
            na = 0;
            if (lines == 8'h30 || lines == 8'he0)
               col = {ab[1][4:0], ab[0]};
            if (lines == 8'h30) begin
               fork
                  begin
                     rdy = 1'b0;
                     #600 rdy = 1'b1;
                  end
               join_none
            end
         end else if (ale && rdy && na < 5) begin
            ab[na] = lines;
            na++;
         end else if (!cle && !ale && rdy && read_strobe_low && wp_n) begin
            din = lines;
            nd++;
         end
      end
   end
   // busy array ignores read strobes, but ce_n still gates its output enable
   always @(negedge read_strobe_low) begin
      if (!ce_n && rdy) begin
         dev_byte = col[7:0] ^ ab[2];
         if (col < 13'(nfc_pkg::PAGE_BYTES - 1))
            col++;
      end
   end
   assign dev_oe_n = ce_n || read_strobe_low || cle || ale || !we_n;
   assign rb_oe_n = rdy;
endmodule

// File: verif/nfc_host_checker.sv
`timescale 1ns/1ns
// pin protocol watcher on the controller's device side
module nfc_host_checker (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       cle,
   input wire logic       ale,
   input wire logic       ce_n,
   input wire logic       we_n,
   input wire logic       read_strobe_low,
   input wire logic       wp_n,
   input wire logic [7:0] byte_out,
   input wire logic       byte_oe_n,
   input wire logic       ready_busy_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_latch_excl: assert property (!(cle && ale))
      else $error("both latch strobes high");
   a_we_selected: assert property (!we_n |-> !ce_n && read_strobe_low)
      else $error("write strobe without select");
   a_cmd_setup: assert property (!we_n && cle |-> !byte_oe_n)
      else $error("command byte not driven");
   a_addr_setup: assert property ($fell(we_n) && ale |-> !byte_oe_n)
      else $error("address byte not driven");
   a_data_wp: assert property (!we_n && !cle && !ale |-> wp_n && !byte_oe_n)
      else $error("data write while protected");
   a_we_pulse: assert property ($fell(we_n) |=> !we_n ##1 we_n)
      else $error("write strobe width wrong");
   a_hold_edge: assert property ($rose(we_n) |-> $stable(byte_out) && $stable(cle))
      else $error("byte moved at latch edge");
   a_read_release: assert property (!read_strobe_low |-> byte_oe_n && !cle && !ale)
      else $error("host drives during read");
   a_read_pulse: assert property ($fell(read_strobe_low) |=> !read_strobe_low[*2] ##1 read_strobe_low)
      else $error("read strobe width wrong");
   c_cmd: cover property ($fell(we_n) && cle);
   c_read: cover property ($fell(read_strobe_low));
   c_busy_cmd: cover property (!ready_busy_flag && !we_n);
endmodule
bind nfc_host nfc_host_checker i_nfc_host_checker (.clk(clk), .rst(rst),
   .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n),
   .read_strobe_low(read_strobe_low), .wp_n(wp_n), .byte_out(byte_out),
   .byte_oe_n(byte_oe_n), .ready_busy_flag(ready_busy_flag));

// File: verif/nfc_host_test.sv
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %0t got %h want %h", $time, g, e); end end
module nfc_host_test;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, wp = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, byte_out, dev_byte, lines, d;
   logic cle, ale, ce_n, we_n, rsl, wp_n, byte_oe_n, dev_oe_n, rb_oe_n, rb;
   int n_fail = 0, check_count = 0;
   // a released bus shows the inverse, so stale bytes never match
   assign lines = !byte_oe_n ? byte_out : (!dev_oe_n ? dev_byte : ~dev_byte);
   assign rb = rb_oe_n ? 1'b1 : 1'b0; // open drain with pull-up
   nfc_host i_nfc_host (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .cle(cle), .ale(ale), .ce_n(ce_n),
      .we_n(we_n), .read_strobe_low(rsl), .wp_n(wp_n), .byte_out(byte_out),
      .byte_oe_n(byte_oe_n), .shared_byte_lines(lines), .ready_busy_flag(rb));
   nfc_flash_model i_nfc_flash_model (.cle(cle), .ale(ale), .ce_n(ce_n),
      .we_n(we_n), .read_strobe_low(rsl), .wp_n(wp_n), .lines(lines),
      .dev_byte(dev_byte), .dev_oe_n(dev_oe_n), .rb_oe_n(rb_oe_n));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wreg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // start an op and poll the engine busy bit, bounded
   task automatic op(input logic [2:0] o);
      logic [7:0] s;
      wreg(nfc_pkg::REG_CTRL, {wp, 4'h0, o});
      for (int i = 0; i < 300; i++) begin
         rreg(nfc_pkg::REG_STAT, s);
         if (s[0] === 1'b0) return;
      end
      n_fail++;
      conclude();
   endtask
   task automatic t_reset();
      `CHK({ce_n, we_n, rsl, wp_n, byte_oe_n}, 5'h1d)
      rreg(nfc_pkg::REG_CMD, d);
      `CHK(d, 8'h00)
      $display("test reset done");
   endtask
   task automatic t_cmds();
      logic [7:0] c [14] = '{8'h00, 8'h05, 8'h80, 8'h10, 8'h60, 8'hd0,
         8'h85, 8'h11, 8'h81, 8'h35, 8'h90, 8'h7a, 8'hff, 8'h30};
      foreach (c[i]) begin
         wreg(nfc_pkg::REG_CMD, c[i]);
         op(nfc_pkg::OP_CMD);
         `CHK(i_nfc_flash_model.cmd, c[i])
      end
      `CHK(rb, 1'b0)
      wreg(nfc_pkg::REG_CMD, 8'h70);
      op(nfc_pkg::OP_CMD);
      `CHK(i_nfc_flash_model.cmd, 8'h70)
      `CHK(rb, 1'b0)
      wreg(nfc_pkg::REG_CMD, 8'h90);
      op(nfc_pkg::OP_CMD);
      rreg(nfc_pkg::REG_STAT, d);
      `CHK(d[2], 1'b1)
      `CHK(i_nfc_flash_model.cmd, 8'h70)
      for (int i = 0; i < 100 && rb !== 1'b1; i++) @(posedge clk);
      `CHK(rb, 1'b1)
      if (rb !== 1'b1) conclude();
      $display("test commands done");
   endtask
   // column in the spare area, high bytes first into the shift registers
   task automatic t_addr();
      wreg(nfc_pkg::REG_COL, 8'h10);
      wreg(nfc_pkg::REG_COL, 8'h05);
      wreg(nfc_pkg::REG_ROW, 8'h03);
      wreg(nfc_pkg::REG_ROW, 8'h45);
      wreg(nfc_pkg::REG_ROW, 8'h67);
      rreg(nfc_pkg::REG_COL, d);
      `CHK(d, 8'h05)
      rreg(nfc_pkg::REG_ROW, d);
      `CHK(d, 8'h67)
      op(nfc_pkg::OP_ADDR);
      `CHK(i_nfc_flash_model.na, 5)
      `CHK({i_nfc_flash_model.ab[0], i_nfc_flash_model.ab[1]}, 16'h0510)
      `CHK(i_nfc_flash_model.ab[2], 8'h67)
      `CHK({i_nfc_flash_model.ab[3], i_nfc_flash_model.ab[4]}, 16'h4503)
      $display("test address done");
   endtask
   task automatic t_page();
      op(nfc_pkg::OP_PGRD);
      `CHK(i_nfc_flash_model.cmd, 8'h30)
      for (int k = 0; k < 3; k++) begin
         op(nfc_pkg::OP_RD);
         rreg(nfc_pkg::REG_DATA, d);
         `CHK(d, (8'h05 + 8'(k)) ^ 8'h67)
      end
      wreg(nfc_pkg::REG_COL, 8'h00);
      wreg(nfc_pkg::REG_COL, 8'h02);
      op(nfc_pkg::OP_COLC);
      op(nfc_pkg::OP_RD);
      rreg(nfc_pkg::REG_DATA, d);
      `CHK(d, 8'h02 ^ 8'h67)
      $display("test page read done");
   endtask
   task automatic t_wp();
      int n;
      n = i_nfc_flash_model.nd;
      wp = 1'b0;
      wreg(nfc_pkg::REG_DATA, 8'h5a);
      op(nfc_pkg::OP_WR);
      rreg(nfc_pkg::REG_STAT, d);
      `CHK(d[2], 1'b1)
      `CHK(i_nfc_flash_model.nd, n)
      wp = 1'b1;
      op(nfc_pkg::OP_WR);
      `CHK(i_nfc_flash_model.din, 8'h5a)
      op(3'h0);
      `CHK(ce_n, 1'b1)
      $display("test protect done");
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_cmds();
      t_addr();
      t_page();
      t_wp();
      conclude();
   end
endmodule
